/* File: common/demux_pkg.sv */
// Constants and carrier types for the converter output demultiplexer.
// Assumes one sample clock domain; the APB register bus runs on that same clock.
package demux_pkg;

    // Width of one sample word
    localparam int SAMPLE_W = 8;

    // Divide select codes on the select input
    localparam logic [2:0] DIV_SEL_HALF = 3'h2;
    localparam logic [2:0] DIV_SEL_QUARTER = 3'h4;

    // Reset values of the output flops
    localparam logic [7:0] WORD_RESET = 8'h00;

    // APB register offsets (byte addresses)
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] SAMPLE_OFS = 12'h008;

    // Control register field positions
    localparam int CTRL_DEMUX_EN = 0;
    localparam int CTRL_AUX_A = 1;
    localparam int CTRL_AUX_B = 2;
    localparam int CTRL_SEL_LO = 4;
    localparam int CTRL_SEL_HI = 6;
    localparam int CTRL_RESET = 8;

    // Control register reset value: demux on, both aux on, divide by two
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0027;

    // Output modes of the demultiplexer
    typedef enum logic [1:0] {
        undivided_mode,
        half_rate_mode,
        quarter_rate_mode
    } demux_mode_e;

    // One sample as delivered by the converter core
    typedef struct packed {
        logic [7:0] word;
        logic over;
    } sample_s;

    // One port word with its complement
    typedef struct packed {
        logic [7:0] bits_true;
        logic [7:0] bits_comp;
    } port_word_s;

endpackage

/* File: rtl/adc_output_demux_overrange.sv */
// Output sequencing of an 8-bit sampling converter: routes samples to a
// primary and auxiliary port, drives shared overrange and data-ready clock.
// Assumes pclk is the sample clock and samples arrive one per clock.
`timescale 1ns/1ps

module adc_output_demux_overrange
    import demux_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter core sample
    input wire sample_s sample_in,
    // Demux reset pin, active high; no pull-down, must be driven
    input wire logic demux_reset_in,
    // Output ports
    output port_word_s primary_port_bits,
    output port_word_s secondary_port_bits,
    output logic overrange,
    output logic overrange_n,
    output logic data_valid_clock,
    output logic data_valid_clock_n,
    output logic aux_port_powered,
    output logic demux_reset_out,
    output logic demux_reset_out_n
);

    // Control register and its next value
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    // Captured sample from the core
    sample_s cap_r;
    // Held first sample of a pair
    sample_s hold_r;
    // Phase counter within an output period
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    // Outputs as registers
    port_word_s prim_r;
    port_word_s aux_r;
    logic or_r;
    logic dvc_r;
    logic rst_out_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    // Registered inverted phases of the output pairs
    logic or_n_r;
    logic dvc_n_r;
    logic rst_out_n_r;
    // Registered aux power state
    logic aux_on_r;

    // How the sequencing works, in short.
    //
    // Sample path: the core hands over one sample per pclk edge. It is
    // registered once in cap_r, so every later choice looks at a settled
    // value and never at the pin directly.
    //
    // Period: phase_r counts within one output period. Undivided mode has
    // a period of one clock, half rate two clocks, quarter rate four.
    // The last phase of a period is where the ports are refreshed.
    //
    // Half rate: the sample seen at phase 0 is parked in hold_r and goes
    // to the primary port; the one at phase 1 goes to the aux port. The
    // primary word is thus always the older of the two.
    //
    // Quarter rate: samples at phases 0 and 2 are kept, those at phases 1
    // and 3 are dropped. The kept pair leaves together at phase 3.
    //
    // Overrange: one shared flag. In the divided modes it is the OR of the
    // two words that leave together; undivided it follows the primary
    // word alone. It is loaded in the same flop update as the words, so
    // a capture edge never sees a flag from a neighbouring period.
    //
    // Data-ready: its rise coincides with the port refresh, so capture
    // logic should use the falling edge, half a period later at best.
    // Limitation: undivided mode refreshes every clock while data-ready
    // can rise only every second clock; capture logic then sees every
    // other word. A faster strobe would need a second clock domain.
    //
    // Demux reset: the pin or the self-clearing control bit holds the
    // phase at zero, blocks port updates and keeps data-ready low. The
    // same level leaves one clock later on the forwarded reset pair, so
    // downstream demux parts restart in step with this one.
    // An undriven pin has no pull-down here and makes the reset unknown, so drive it low.
    //
    // Mode changes: the period length follows the control word at once,
    // so the first period after a change can be short. Issue a demux
    // reset after any mode change before trusting the output stream.
    //
    // Single device: the phase counter alone fixes which sample goes to
    // which port, so the port order never depends on data-ready phase.
    //
    // Outputs: every pin is a flop, complements included, so the true and
    // inverted phases of each pair switch on the same edge.

    // Decoded control fields
    wire demux_enable = ctrl_r[CTRL_DEMUX_EN];
    wire aux_port_enable_a = ctrl_r[CTRL_AUX_A];
    wire aux_port_enable_b = ctrl_r[CTRL_AUX_B];
    wire [2:0] divide_select = ctrl_r[CTRL_SEL_HI:CTRL_SEL_LO];
    wire soft_reset = ctrl_r[CTRL_RESET];

    // Aux port off only when both enables are low
    wire aux_on = aux_port_enable_a | aux_port_enable_b;

    // Mode decode; select ignored while demux is disabled
    demux_mode_e mode;
    assign mode = !demux_enable ? undivided_mode :
        (divide_select == DIV_SEL_QUARTER) ? quarter_rate_mode :
        half_rate_mode;

    // Internal demux reset: pin or software pulse; the pin has no pull-down
    wire demux_reset = demux_reset_in | soft_reset;

    // APB decode
    wire apb_setup = psel & ~penable;
    wire apb_wr = apb_setup & pwrite;
    wire apb_rd = apb_setup & ~pwrite;
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_status = (paddr == STATUS_OFS);
    wire hit_sample = (paddr == SAMPLE_OFS);
    wire hit_any = hit_ctrl | hit_status | hit_sample;

    // Status word shows mode, phase and live outputs
    wire [31:0] status_word = {24'h0, 1'b0, or_r, phase_r, aux_on,
        1'b0, mode};
    wire [31:0] sample_word = {16'h0, aux_r.bits_true, prim_r.bits_true};
    wire [31:0] rd_word = hit_ctrl ? ctrl_r :
        hit_status ? status_word :
        hit_sample ? sample_word : 32'h0;

    // Control write; reset bit self-clears after one cycle
    always_comb begin
        ctrl_nxt = ctrl_r;
        ctrl_nxt[CTRL_RESET] = 1'b0;
        if (apb_wr && hit_ctrl) begin
            // Only the defined control bits are stored
            ctrl_nxt = pwdata & 32'h0000_0177;
        end
    end

    // Period length: one clock undivided, two half, four quarter
    wire [1:0] last_phase = (mode == undivided_mode) ? 2'h0 :
        (mode == half_rate_mode) ? 2'h1 : 2'h3;
    // Phase advance; demux reset restarts the sequence
    always_comb begin
        if (demux_reset || phase_r >= last_phase) begin
            phase_nxt = 2'h0;
        end else begin
            phase_nxt = phase_r + 2'h1;
        end
    end

    // Output update moment: end of period
    wire out_edge = !demux_reset && (phase_r == last_phase);
    // Quarter mode keeps samples at phases 0 and 2 only
    wire hold_take = (mode == quarter_rate_mode) ? (phase_r == 2'h0) :
        (phase_r == 2'h0);
    wire aux_take_q = (phase_r == 2'h2);

    // APB slave: one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET_VAL;
            prdata_r <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            // Control word follows its next value every clock
            ctrl_r <= ctrl_nxt;
            // Answer always in the cycle after setup
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~hit_any;
            // Read data prepared in setup, valid in access
            if (apb_rd) begin
                prdata_r <= rd_word;
            end
        end
    end

    // Sample capture on every clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_r <= '0;
            phase_r <= 2'h0;
        end else begin
            // One register stage ahead of all routing choices
            cap_r <= sample_in;
            phase_r <= phase_nxt;
        end
    end

    // First sample of the pair held until the period ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= '0;
        end else if (hold_take) begin
            // Older sample of the pair
            hold_r <= cap_r;
        end
    end

    // Second kept sample of a quarter period, taken at phase 2
    sample_s aux_hold_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_hold_r <= '0;
        end else if (aux_take_q) begin
            // The phase 3 sample is the dropped one
            aux_hold_r <= cap_r;
        end
    end

    // Auxiliary candidate: phase 1 in half, phase 2 in quarter
    sample_s aux_src;
    assign aux_src = (mode == quarter_rate_mode) ?
        (aux_take_q ? cap_r : aux_hold_r) : cap_r;

    // Words and overrange for the next output period
    sample_s prim_src;
    assign prim_src = (mode == undivided_mode) ? cap_r : hold_r;
    wire or_nxt = (mode == undivided_mode) ? prim_src.over :
        (prim_src.over | aux_src.over);

    // Port outputs change together with the data-ready rising edge in the divided modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prim_r <= {WORD_RESET, ~WORD_RESET};
            aux_r <= {WORD_RESET, ~WORD_RESET};
            or_r <= 1'b0;
            or_n_r <= 1'b1;
        end else if (out_edge) begin
            prim_r <= {prim_src.word, ~prim_src.word};
            // Powered-down aux port parks at zero
            if (aux_on && mode != undivided_mode) begin
                aux_r <= {aux_src.word, ~aux_src.word};
            end else begin
                aux_r <= {WORD_RESET, ~WORD_RESET};
            end
            or_r <= or_nxt;
            // Complement flop keeps the pair exactly opposite
            or_n_r <= ~or_nxt;
        end
    end

    // Data-ready next level: rises with output update, falls mid-period in the divided modes
    logic dvc_nxt;
    always_comb begin
        if (demux_reset) begin
            // Held low while the demux restarts
            dvc_nxt = 1'b0;
        end else if (mode == undivided_mode) begin
            // Undivided: toggles, one rise per two samples
            dvc_nxt = ~dvc_r;
        end else begin
            // Divided: high from the update into the first half
            dvc_nxt = out_edge | (phase_r < (last_phase >> 1));
        end
    end

    // Data-ready pair registered side by side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dvc_r <= 1'b0;
            dvc_n_r <= 1'b1;
        end else begin
            dvc_r <= dvc_nxt;
            dvc_n_r <= ~dvc_nxt;
        end
    end

    // Reset forwarded to external demux devices, both phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_out_r <= 1'b0;
            rst_out_n_r <= 1'b1;
        end else begin
            rst_out_r <= demux_reset;
            rst_out_n_r <= ~demux_reset;
        end
    end

    // Aux power state registered so the pin comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Reset control word decides the power state
            aux_on_r <= CTRL_RESET_VAL[CTRL_AUX_A] |
                CTRL_RESET_VAL[CTRL_AUX_B];
        end else begin
            aux_on_r <= aux_on;
        end
    end

    // Output drive
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign primary_port_bits = prim_r;
    assign secondary_port_bits = aux_r;
    assign overrange = or_r;
    assign overrange_n = or_n_r;
    assign data_valid_clock = dvc_r;
    assign data_valid_clock_n = dvc_n_r;
    assign aux_port_powered = aux_on_r;
    assign demux_reset_out = rst_out_r;
    assign demux_reset_out_n = rst_out_n_r;

endmodule

/* File: testbench/adc_output_demux_overrange_asserts.sv */
// Port checks for the converter output demultiplexer.
// Assumes it is bound to the top module; pclk is the only clock.
`timescale 1ns/1ps
module adc_output_demux_overrange_asserts
    import demux_pkg::*;
(
    // Clock, reset and bus handshake
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Demux pins and output ports
    input wire logic demux_reset_in,
    input wire port_word_s primary_port_bits,
    input wire port_word_s secondary_port_bits,
    input wire logic overrange,
    input wire logic overrange_n,
    input wire logic data_valid_clock,
    input wire logic data_valid_clock_n,
    input wire logic aux_port_powered,
    input wire logic demux_reset_out,
    input wire logic demux_reset_out_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Any port update while the aux port runs
    sequence port_update;
        aux_port_powered && ($changed(primary_port_bits) ||
            $changed(secondary_port_bits) || $changed(overrange));
    endsequence
    a_primary_comp: assert property (
        primary_port_bits.bits_comp == ~primary_port_bits.bits_true)
        else $error("primary complement wrong");
    a_aux_comp: assert property (
        secondary_port_bits.bits_comp == ~secondary_port_bits.bits_true)
        else $error("aux complement wrong");
    a_or_comp: assert property (overrange_n == ~overrange)
        else $error("overrange complement wrong");
    a_dvc_comp: assert property (
        data_valid_clock_n == ~data_valid_clock)
        else $error("data-ready complement wrong");
    a_change_on_rise: assert property (
        port_update |-> $rose(data_valid_clock))
        else $error("ports changed without data-ready rise");
    a_demux_reset_out_follows: assert property (
        $rose(demux_reset_in) |-> ##[1:3] demux_reset_out)
        else $error("reset not forwarded");
    a_demux_reset_out_idle: assert property (
        !demux_reset_in [*4] |-> !demux_reset_out)
        else $error("reset out without reset in");
    a_aux_parked: assert property (
        !aux_port_powered [*4] |-> secondary_port_bits.bits_true == 8'h00)
        else $error("aux port active while off");
    a_bus_answer: assert property (psel && !penable |=> pready)
        else $error("no answer in access phase");
endmodule
bind adc_output_demux_overrange adc_output_demux_overrange_asserts u_chk (
    .pclk, .presetn, .psel, .penable, .pready, .demux_reset_in,
    .primary_port_bits, .secondary_port_bits, .overrange, .overrange_n,
    .data_valid_clock, .data_valid_clock_n, .aux_port_powered,
    .demux_reset_out, .demux_reset_out_n);

/* File: testbench/adc_output_demux_overrange_test.sv */
// Testbench: sets each mode over APB, checks the captured port stream.
// Assumes a wait-free APB slave and one core sample per clock.
`timescale 1ns/1ps
module adc_output_demux_overrange_test import demux_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, demux_reset_in = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, overrange, dvc, aux_on, rst_out;
    sample_s sample_in = '0;
    port_word_s pri, aux;
    logic [7:0] cnt = 8'h00;
    int fail_count = 0, samples_checked = 0;
    // 50 MHz sample clock
    always #10 pclk = ~pclk;
    // Converter core: ramp, flagged when the low bits are 7
    always @(posedge pclk) begin
        cnt <= cnt + 8'h01;
        sample_in <= '{word: cnt, over: cnt[2:0] == 3'h7};
    end
    adc_output_demux_overrange dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_in,
        .demux_reset_in, .primary_port_bits(pri), .secondary_port_bits(aux),
        .overrange, .overrange_n(), .data_valid_clock(dvc),
        .data_valid_clock_n(), .aux_port_powered(aux_on),
        .demux_reset_out(rst_out), .demux_reset_out_n());
    demux_capture_model cap (.data_valid_clock(dvc), .primary_port_bits(pri),
        .secondary_port_bits(aux), .overrange);
    // Compare one value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer; result left in rd and err
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            fail_count++;
            print_verdict;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Set a mode, resync the demux, then check the captured pairs
    task automatic run_mode(input logic [31:0] ctrl, input logic [1:0] md);
        logic [7:0] p, s;
        int n;
        apb(1'b1, CTRL_OFS, ctrl);
        apb(1'b0, STATUS_OFS, 32'h0);
        check(rd[1:0], md);
        check(aux_on, ctrl[2:1] != 2'b00);
        demux_reset_in <= 1'b1;
        repeat (3) @(posedge pclk);
        demux_reset_in <= 1'b0;
        cap.cap_q.delete();
        n = 0;
        while (cap.cap_q.size() < 12 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        if (n == 300) begin
            fail_count++;
            print_verdict;
        end
        for (int i = 3; i < 12; i++) begin
            p = cap.cap_q[i][7:0];
            s = cap.cap_q[i][15:8];
            if (md == 2'd0) begin
                check(s, 8'h00);
                check(cap.cap_q[i][16], p[2:0] == 3'h7);
            end else begin
                check(s, 8'(p + md));
                check(8'(p - cap.cap_q[i-1][7:0]), {md, 1'b0});
                check(cap.cap_q[i][16], p[2:0] == 3'h7 || s[2:0] == 3'h7);
            end
        end
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0);
        check(rd, CTRL_RESET_VAL);
        apb(1'b0, 12'h010, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        run_mode(32'h0000_0000, 2'd0);
        run_mode(32'h0000_0027, 2'd1);
        run_mode(32'h0000_0047, 2'd2);
        print_verdict;
    end
endmodule

/* File: testbench/demux_capture_model.sv */
// Downstream capture logic: latches port words on the data-ready fall.
// Assumes outputs settle a moment after the launching pclk edge.
`timescale 1ns/1ps
module demux_capture_model
    import demux_pkg::*;
(
    // Observed output ports
    input wire logic data_valid_clock,
    input wire port_word_s primary_port_bits,
    input wire port_word_s secondary_port_bits,
    input wire logic overrange
);
    // Captured {overrange, aux word, primary word}
    logic [16:0] cap_q[$];
    // Sample on the opposite edge of data-ready
    always @(negedge data_valid_clock) begin
        #1;
        cap_q.push_back({overrange, secondary_port_bits.bits_true,
            primary_port_bits.bits_true});
    end
endmodule
